// ---- hdl/gpb_dev.sv ----
// instrument end of the bus: talker, listener, polls, remote/local, clear, trigger
//
// What this block does
// R1 - bytes on data lines, singles on management lines
// R2 - one multi-line byte on the bus
// R3 - clear, remote enable, attention obeyed always
// R4 - addressed commands need prior addressing
// R5 - top data bit never decoded
// R6 - five-bit address, all ones means none
// R7 - decode listen, talk, secondary under attention
// R8 - secondary only extends a preceding primary
// R9 - no controller, no two-byte addresses
// R10 - full source and acceptor handshakes
// R11 - basic talker returns status when polled
// R12 - request service on service request line
// R13 - remote, local and lockout under enable
// R14 - configurable parallel poll answer with sense
// R15 - universal and selected clear reset device
// R16 - trigger command acts when listening
// R17 - drivers are three-state, released when idle
// R18 - all monitor commands, only addressed move data
// R19 - byte steps wait on three handshake lines
// R20 - status bit six flags service request
// R21 - attention with end answers parallel poll
// R22 - match own address, other talk unaddresses
// R23 - interface clear idles talker, listener, polls
`timescale 1ns/10ps
`include "gpb_regs.svh"
module gpb_dev (
   input wire logic clk_sys_i,        // 40 MHz system clock
   input wire logic rst_b_i,          // async reset, active low
   gpb_if.dev bus,                    // instrument bus pins
   input wire logic [4:0] my_addr_i,  // configured bus address
   output logic [7:0] rx_data_o,      // received data byte
   output logic rx_end_o,             // byte came with end marker
   output logic rx_valid_o,           // received byte waiting
   input wire logic rx_ready_i,       // user takes received byte
   input wire logic [7:0] tx_data_i,  // byte to talk
   input wire logic tx_end_i,         // mark byte as last
   input wire logic tx_valid_i,       // talk byte offered
   output logic tx_ready_o,           // talk byte accepted this cycle
   input wire logic rsv_i,            // device wants service
   input wire logic [7:0] status_i,   // device status, bit six replaced
   input wire logic ist_i,            // parallel poll status
   output logic listen_o,             // addressed to listen
   output logic talk_o,               // addressed to talk
   output logic remote_o,             // under remote control
   output logic lockout_o,            // local lockout active
   output logic trigger_o,            // trigger pulse
   output logic clear_o               // device clear pulse
);
   gpb_pkg::gpb_dev_st_t st_r, st_nxt;

   logic part, talk_ok, pp_resp, pop;
   logic [6:0] cmd;
   logic [4:0] adr;

   always_comb begin
      st_nxt = st_r;
      st_nxt.trig = 1'b0;
      st_nxt.clr = 1'b0;
      part = bus.atn | st_r.lad; // R18
      talk_ok = st_r.tad & ~bus.atn & ~bus.ifc; // R18
      pop = st_r.rxv & rx_ready_i;
      cmd = bus.dio[6:0]; // R5
      adr = cmd[4:0];
      // two-entry receive buffer: head feeds the user directly
      if (pop) begin
         st_nxt.hd = st_r.sd;
         st_nxt.cnt = st_r.cnt - 2'h1;
      end
      // acceptor handshake
      case (st_r.ah)
         gpb_pkg::AH_IDLE: begin
            // hold not-ready on a full buffer unless attention is set; a ready kept after attention drops still takes a byte
            if (part && !bus.dav && (bus.atn || st_nxt.cnt != `GPB_FIFO_DEPTH)) begin // R19
               st_nxt.ah = gpb_pkg::AH_READY;
            end
         end
         gpb_pkg::AH_READY: begin
            if (!part) begin
               st_nxt.ah = gpb_pkg::AH_IDLE;
            end else if (bus.dav) begin // R19 R10
               st_nxt.ah = gpb_pkg::AH_ACPT;
               if (bus.atn) begin // R3 R18
                  case (cmd[6:5]) // R7
                     `GPB_GRP_LSN: begin
                        st_nxt.pp_pend = 1'b0;
                        if (adr == `GPB_ADDR_NONE) begin // R6
                           st_nxt.lad = 1'b0;
                        end else if (adr == my_addr_i) begin // R22
                           st_nxt.lad = 1'b1;
                           if (bus.ren) begin
                              st_nxt.rem = 1'b1; // R13
                           end
                        end
                     end
                     `GPB_GRP_TLK: begin
                        st_nxt.pp_pend = 1'b0;
                        // a single talker: any other talk address unaddresses us
                        st_nxt.tad = (adr == my_addr_i) && (adr != `GPB_ADDR_NONE); // R22 R6
                     end
                     `GPB_GRP_SEC: begin
                        // secondaries act only after a configure command; no extended addressing
                        if (adr != `GPB_ADDR_NONE && st_r.pp_pend) begin // R8 R9 R14
                           st_nxt.pp_en = ~adr[`GPB_SEC_PPD_BIT];
                           if (!adr[`GPB_SEC_PPD_BIT]) begin
                              st_nxt.pp_sense = adr[`GPB_PPE_SENSE_BIT];
                              st_nxt.pp_line = adr[2:0];
                           end
                        end
                     end
                     default: begin
                        st_nxt.pp_pend = 1'b0;
                        case (adr)
                           `GPB_CMD_LLO: st_nxt.llo = bus.ren; // R13
                           `GPB_CMD_DCL: st_nxt.clr = 1'b1; // R15
                           `GPB_CMD_PPU: st_nxt.pp_en = 1'b0; // R14
                           `GPB_CMD_SPE: st_nxt.spms = 1'b1; // R11
                           `GPB_CMD_SPD: st_nxt.spms = 1'b0; // R11
                           `GPB_CMD_GTL: begin
                              if (st_r.lad && !st_r.llo) begin // R4 R13
                                 st_nxt.rem = 1'b0;
                              end
                           end
                           `GPB_CMD_SDC: st_nxt.clr = st_r.lad; // R4 R15
                           `GPB_CMD_PPC: st_nxt.pp_pend = st_r.lad; // R4 R14
                           `GPB_CMD_GET: st_nxt.trig = st_r.lad; // R4 R16
                           default: st_nxt.pp_pend = 1'b0;
                        endcase
                     end
                  endcase
               end else begin
                  if (st_nxt.cnt == 2'h0) begin
                     st_nxt.hd = {bus.eoi, bus.dio}; // R1
                  end else begin
                     st_nxt.sd = {bus.eoi, bus.dio};
                  end
                  st_nxt.cnt = st_nxt.cnt + 2'h1;
               end
            end
         end
         gpb_pkg::AH_ACPT: begin
            if (!bus.dav) begin // R19
               st_nxt.ah = gpb_pkg::AH_IDLE;
            end
         end
         default: st_nxt.ah = gpb_pkg::AH_IDLE;
      endcase
      // source handshake; attention aborts a byte in flight
      case (st_r.sh)
         gpb_pkg::SH_IDLE: begin
            if (talk_ok && st_r.spms) begin // R11
               st_nxt.dio_o = status_i;
               st_nxt.dio_o[`GPB_STB_RSV_BIT] = rsv_i; // R20
               st_nxt.eoi = 1'b0;
               st_nxt.sh = gpb_pkg::SH_SETTLE;
            end else if (talk_ok && tx_valid_i && st_r.tx_rdy) begin // R10
               st_nxt.dio_o = tx_data_i;
               st_nxt.eoi = tx_end_i;
               st_nxt.sh = gpb_pkg::SH_SETTLE;
            end
         end
         gpb_pkg::SH_SETTLE: begin
            if (!talk_ok) begin
               st_nxt.sh = gpb_pkg::SH_IDLE;
            end else if (!bus.nrfd && bus.ndac) begin // R19
               st_nxt.sh = gpb_pkg::SH_DAV;
            end
         end
         gpb_pkg::SH_DAV: begin
            if (!talk_ok || !bus.ndac) begin // R19
               st_nxt.sh = gpb_pkg::SH_IDLE;
            end
         end
         default: st_nxt.sh = gpb_pkg::SH_IDLE;
      endcase
      if (!bus.ren) begin // R3 R13
         st_nxt.rem = 1'b0;
         st_nxt.llo = 1'b0;
      end
      if (bus.ifc) begin // R3 R23
         st_nxt.lad = 1'b0;
         st_nxt.tad = 1'b0;
         st_nxt.spms = 1'b0;
         st_nxt.pp_pend = 1'b0;
         st_nxt.ah = gpb_pkg::AH_IDLE;
         st_nxt.sh = gpb_pkg::SH_IDLE;
      end
      // pin images, registered so every pin but dev_dav_oe comes from a flop
      st_nxt.rxv = st_nxt.cnt != 2'h0;
      st_nxt.tx_rdy = st_nxt.tad & ~bus.atn & ~bus.ifc & ~st_nxt.spms
         & (st_nxt.sh == gpb_pkg::SH_IDLE);
      st_nxt.nrfd = part & ~bus.ifc & (st_nxt.ah != gpb_pkg::AH_READY); // R19
      st_nxt.ndac = part & ~bus.ifc & (st_nxt.ah != gpb_pkg::AH_ACPT); // R19
      st_nxt.dav = st_nxt.sh == gpb_pkg::SH_DAV;
      st_nxt.srq = rsv_i & ~(st_nxt.spms & st_nxt.tad); // R12
      pp_resp = bus.atn & bus.eoi & st_r.pp_en & ~bus.ifc; // R21 R14
      if (st_nxt.sh != gpb_pkg::SH_IDLE) begin // R2 R17
         st_nxt.dio_oe = 8'hff;
      end else if (pp_resp && (ist_i == st_r.pp_sense)) begin // R21
         st_nxt.dio_oe = 8'h01 << st_r.pp_line;
         st_nxt.dio_o = st_nxt.dio_oe;
      end else begin
         st_nxt.dio_oe = 8'h00; // R17
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.dev_dio_o = st_r.dio_o;
   assign bus.dev_dio_oe = st_r.dio_oe;
   assign bus.dev_dav_o = st_r.dav;
   assign bus.dev_dav_oe = st_r.sh != gpb_pkg::SH_IDLE; // R17
   assign bus.dev_eoi_o = st_r.eoi;
   assign bus.dev_eoi_oe = st_r.dav;
   assign bus.dev_nrfd_o = st_r.nrfd;
   assign bus.dev_nrfd_oe = st_r.nrfd;
   assign bus.dev_ndac_o = st_r.ndac;
   assign bus.dev_ndac_oe = st_r.ndac;
   assign bus.dev_srq_o = st_r.srq;
   assign bus.dev_srq_oe = st_r.srq;
   assign rx_data_o = st_r.hd[7:0];
   assign rx_end_o = st_r.hd[8];
   assign rx_valid_o = st_r.rxv;
   assign tx_ready_o = st_r.tx_rdy;
   assign listen_o = st_r.lad;
   assign talk_o = st_r.tad;
   assign remote_o = st_r.rem;
   assign lockout_o = st_r.llo;
   assign trigger_o = st_r.trig;
   assign clear_o = st_r.clr;
endmodule

// ---- hdl/gpb_regs.svh ----
// constants shared by both ends of the instrument bus link
`ifndef GPB_REGS_SVH
`define GPB_REGS_SVH
`define GPB_CLK_NS 25
`define GPB_PP_WAIT_NS 200
`define GPB_PP_WAIT_CYC ((`GPB_PP_WAIT_NS + `GPB_CLK_NS - 1) / `GPB_CLK_NS)
`define GPB_ADDR_NONE 5'h1f
`define GPB_GRP_CMD 2'h0
`define GPB_GRP_LSN 2'h1
`define GPB_GRP_TLK 2'h2
`define GPB_GRP_SEC 2'h3
`define GPB_CMD_GTL 5'h01
`define GPB_CMD_SDC 5'h04
`define GPB_CMD_PPC 5'h05
`define GPB_CMD_GET 5'h08
`define GPB_CMD_LLO 5'h11
`define GPB_CMD_DCL 5'h14
`define GPB_CMD_PPU 5'h15
`define GPB_CMD_SPE 5'h18
`define GPB_CMD_SPD 5'h19
`define GPB_SEC_PPD_BIT 4
`define GPB_PPE_SENSE_BIT 3
`define GPB_STB_RSV_BIT 6
`define GPB_FIFO_DEPTH 2'h2
`endif

// ---- hdl/gpb_pkg.sv ----
// state types for the instrument bus ends
package gpb_pkg;
   typedef enum logic [1:0] {AH_IDLE = 2'b00, AH_READY = 2'b01, AH_ACPT = 2'b10} gpb_ah_t;
   typedef enum logic [1:0] {SH_IDLE = 2'b00, SH_SETTLE = 2'b01, SH_DAV = 2'b10} gpb_sh_t;
   typedef struct packed {
      gpb_ah_t ah;
      gpb_sh_t sh;
      logic lad, tad, spms, rem, llo, pp_en, pp_sense, pp_pend;
      logic [2:0] pp_line;
      logic [8:0] hd, sd;
      logic [1:0] cnt;
      logic rxv, tx_rdy, trig, clr, srq, dav, nrfd, ndac, eoi;
      logic [7:0] dio_o, dio_oe;
   } gpb_dev_st_t;
   typedef struct packed {
      gpb_ah_t ah;
      gpb_sh_t sh;
      logic atn, eoi_d, cmd_rdy, pp_busy, ppv, rxe, rxv, ifc, ren, srq, nrfd, ndac;
      logic [7:0] pp_cnt, dout, ppd, rxd;
   } gpb_ctl_st_t;
endpackage

// ---- hdl/gpb_if.sv ----
// bus wires between controller end and device end, wired-or of driven true levels
`timescale 1ns/10ps
interface gpb_if;
   logic [7:0] dio, ctl_dio_o, ctl_dio_oe, dev_dio_o, dev_dio_oe;
   logic dav, nrfd, ndac, atn, eoi, ifc, ren, srq;
   logic ctl_dav_o, ctl_dav_oe, ctl_nrfd_o, ctl_nrfd_oe, ctl_ndac_o, ctl_ndac_oe;
   logic ctl_eoi_o, ctl_eoi_oe, ctl_atn_o, ctl_ifc_o, ctl_ren_o;
   logic dev_dav_o, dev_dav_oe, dev_nrfd_o, dev_nrfd_oe, dev_ndac_o, dev_ndac_oe;
   logic dev_eoi_o, dev_eoi_oe, dev_srq_o, dev_srq_oe;
   genvar g;
   for (g = 0; g < 8; g++) begin : g_dio
      assign dio[g] = (ctl_dio_oe[g] & ctl_dio_o[g]) | (dev_dio_oe[g] & dev_dio_o[g]);
   end
   assign dav = (ctl_dav_oe & ctl_dav_o) | (dev_dav_oe & dev_dav_o);
   assign nrfd = (ctl_nrfd_oe & ctl_nrfd_o) | (dev_nrfd_oe & dev_nrfd_o);
   assign ndac = (ctl_ndac_oe & ctl_ndac_o) | (dev_ndac_oe & dev_ndac_o);
   assign eoi = (ctl_eoi_oe & ctl_eoi_o) | (dev_eoi_oe & dev_eoi_o);
   assign srq = dev_srq_oe & dev_srq_o;
   assign atn = ctl_atn_o;
   assign ifc = ctl_ifc_o;
   assign ren = ctl_ren_o;
   modport dev (input dio, dav, nrfd, ndac, atn, eoi, ifc, ren,
      output dev_dio_o, dev_dio_oe, dev_dav_o, dev_dav_oe, dev_nrfd_o, dev_nrfd_oe,
      dev_ndac_o, dev_ndac_oe, dev_eoi_o, dev_eoi_oe, dev_srq_o, dev_srq_oe);
   modport ctl (input dio, dav, nrfd, ndac, eoi, srq,
      output ctl_dio_o, ctl_dio_oe, ctl_dav_o, ctl_dav_oe, ctl_nrfd_o, ctl_nrfd_oe,
      ctl_ndac_o, ctl_ndac_oe, ctl_eoi_o, ctl_eoi_oe, ctl_atn_o, ctl_ifc_o, ctl_ren_o);
endinterface

// ---- hdl/gpb_ctl.sv ----
// controller end of the bus: sends commands and data, polls, receives talker bytes
`timescale 1ns/10ps
`include "gpb_regs.svh"
module gpb_ctl (
   input wire logic clk_sys_i,        // 40 MHz system clock
   input wire logic rst_b_i,          // async reset, active low
   gpb_if.ctl bus,                    // instrument bus pins
   input wire logic [7:0] cmd_data_i, // byte to send
   input wire logic cmd_atn_i,        // send as command under attention
   input wire logic cmd_end_i,        // data byte is last
   input wire logic cmd_valid_i,      // byte offered
   output logic cmd_ready_o,          // byte accepted this cycle
   input wire logic ifc_i,            // interface clear level
   input wire logic ren_i,            // remote enable level
   input wire logic poll_i,           // start a parallel poll
   output logic [7:0] poll_data_o,    // parallel poll answer
   output logic poll_valid_o,         // poll answer pulse
   input wire logic listen_i,         // accept talker bytes
   output logic [7:0] rx_data_o,      // byte from talker
   output logic rx_end_o,             // byte came with end marker
   output logic rx_valid_o,           // byte pulse
   output logic srq_o                 // service requested
);
   gpb_pkg::gpb_ctl_st_t st_r, st_nxt;
   logic part;

   always_comb begin
      st_nxt = st_r;
      st_nxt.ppv = 1'b0;
      st_nxt.rxv = 1'b0;
      st_nxt.ifc = ifc_i;
      st_nxt.ren = ren_i;
      st_nxt.srq = bus.srq; // R12
      part = listen_i & ~st_r.atn;
      case (st_r.sh)
         gpb_pkg::SH_IDLE: begin
            if (st_r.pp_busy) begin
               // answers need time to settle on the data lines before sampling
               if (st_r.pp_cnt == 8'(`GPB_PP_WAIT_CYC)) begin // R21
                  st_nxt.pp_busy = 1'b0;
                  st_nxt.ppd = bus.dio;
                  st_nxt.ppv = 1'b1;
               end else begin
                  st_nxt.pp_cnt = st_r.pp_cnt + 8'h01;
               end
            end else if (poll_i) begin
               st_nxt.pp_busy = 1'b1;
               st_nxt.atn = 1'b1;
               st_nxt.pp_cnt = 8'h00;
            end else if (cmd_valid_i && cmd_atn_i != st_r.atn) begin
               st_nxt.atn = cmd_atn_i;
            end else if (cmd_valid_i && st_r.cmd_rdy) begin // R2
               st_nxt.dout = cmd_data_i;
               st_nxt.eoi_d = cmd_end_i & ~cmd_atn_i;
               st_nxt.sh = gpb_pkg::SH_SETTLE;
            end
         end
         gpb_pkg::SH_SETTLE: begin
            if (!bus.nrfd && bus.ndac) begin // R19
               st_nxt.sh = gpb_pkg::SH_DAV;
            end
         end
         gpb_pkg::SH_DAV: begin
            if (!bus.ndac) begin // R19
               st_nxt.sh = gpb_pkg::SH_IDLE;
            end
         end
         default: st_nxt.sh = gpb_pkg::SH_IDLE;
      endcase
      case (st_r.ah)
         gpb_pkg::AH_IDLE: begin
            if (part && !bus.dav) begin
               st_nxt.ah = gpb_pkg::AH_READY;
            end
         end
         gpb_pkg::AH_READY: begin
            if (!part) begin
               st_nxt.ah = gpb_pkg::AH_IDLE;
            end else if (bus.dav) begin // R19
               st_nxt.rxd = bus.dio;
               st_nxt.rxe = bus.eoi;
               st_nxt.rxv = 1'b1;
               st_nxt.ah = gpb_pkg::AH_ACPT;
            end
         end
         gpb_pkg::AH_ACPT: begin
            if (!bus.dav) begin
               st_nxt.ah = gpb_pkg::AH_IDLE;
            end
         end
         default: st_nxt.ah = gpb_pkg::AH_IDLE;
      endcase
      st_nxt.cmd_rdy = (st_nxt.sh == gpb_pkg::SH_IDLE) & ~st_nxt.pp_busy & ~poll_i
         & (cmd_atn_i == st_nxt.atn);
      st_nxt.nrfd = part & (st_nxt.ah != gpb_pkg::AH_READY);
      st_nxt.ndac = part & (st_nxt.ah != gpb_pkg::AH_ACPT);
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.ctl_dio_o = st_r.dout;
   assign bus.ctl_dio_oe = {8{st_r.sh != gpb_pkg::SH_IDLE}};
   assign bus.ctl_dav_o = st_r.sh == gpb_pkg::SH_DAV;
   assign bus.ctl_dav_oe = st_r.sh != gpb_pkg::SH_IDLE;
   assign bus.ctl_eoi_o = st_r.pp_busy | st_r.eoi_d;
   assign bus.ctl_eoi_oe = st_r.pp_busy | (st_r.sh != gpb_pkg::SH_IDLE);
   assign bus.ctl_nrfd_o = st_r.nrfd;
   assign bus.ctl_nrfd_oe = st_r.nrfd;
   assign bus.ctl_ndac_o = st_r.ndac;
   assign bus.ctl_ndac_oe = st_r.ndac;
   assign bus.ctl_atn_o = st_r.atn;
   assign bus.ctl_ifc_o = st_r.ifc;
   assign bus.ctl_ren_o = st_r.ren;
   assign cmd_ready_o = st_r.cmd_rdy;
   assign poll_data_o = st_r.ppd;
   assign poll_valid_o = st_r.ppv;
   assign rx_data_o = st_r.rxd;
   assign rx_end_o = st_r.rxe;
   assign rx_valid_o = st_r.rxv;
   assign srq_o = st_r.srq;
endmodule

// ---- sim/gpb_link_props.sv ----
// bus-level checks on the wires joining controller and device ends
`timescale 1ns/10ps
module gpb_link_props (
   input wire logic clk_sys_i, // system clock
   input wire logic rst_b_i, // reset, active low
   input wire logic [7:0] dio, // data lines
   input wire logic [7:0] dev_dio_oe, // device data enables
   input wire logic dav, // data valid
   input wire logic nrfd, // not ready
   input wire logic ndac, // not accepted
   input wire logic atn, // attention
   input wire logic eoi, // end or identify
   input wire logic ifc, // interface clear
   input wire logic dev_dav_o, // device data valid
   input wire logic dev_dav_oe // device data valid enable
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);
   // command bytes only: under attention every device must accept, so no stall
   sequence s_cmd_offer;
      atn && !nrfd && ndac ##1 $rose(dav);
   endsequence
   sequence s_taken;
      !ndac && nrfd ##1 !dav;
   endsequence
   AST_CMD_HANDSHAKE: assert property (s_cmd_offer |=> s_taken)
      else $error("command handshake out of step");
   AST_DAV_CAUSE: assert property ($rose(dav) |-> $past(!nrfd && ndac))
      else $error("valid raised before acceptors ready");
   AST_DAV_HELD: assert property (dav && ndac && $stable(atn) && !ifc |=> dav)
      else $error("valid dropped before acceptance");
   AST_DIO_STEADY: assert property (dav && $past(dav) |-> $stable(dio))
      else $error("data lines moved while valid");
   AST_ATN_STOPS_TALKER: assert property (atn |=> !(dev_dav_oe && dev_dav_o))
      else $error("device sourced data under attention");
   AST_CMD_NO_DEV_DIO: assert property (atn && !eoi |=> dev_dio_oe == 8'h00)
      else $error("device drove data lines in command phase");
   AST_PP_ONE_LINE: assert property (atn && eoi |=> $onehot0(dev_dio_oe))
      else $error("poll answer on several lines");
   AST_IFC_RELEASES: assert property (ifc && !eoi |=> dev_dio_oe == 8'h00)
      else $error("device kept driving during interface clear");
endmodule

// ---- sim/tb_top.sv ----
// bench: user sides of both ends, commands, data and polls across the bus
`timescale 1ns/10ps
module tb_top;
   localparam logic [4:0] MY = 5'h0b;
   localparam logic [4:0] OTHER = 5'h03;
   localparam logic [7:0] TC_SEQ [6] = '{8'h08, 8'h04, 8'h3f, 8'h08, 8'h04, 8'h14};
   logic clk_sys_i, rst_b_i, cmd_atn, cmd_end, cmd_valid, cmd_ready, ifc, ren, poll;
   logic poll_valid, ctl_listen, ctl_rx_end, ctl_rx_valid, srq, dev_rx_end, dev_rx_valid;
   logic dev_rx_ready, tx_end, tx_valid, tx_ready, rsv, ist, listen, talk, remote, lockout;
   logic trig, clr;
   logic [7:0] cmd_data, tx_data, status, poll_data, dev_rx_data, ctl_rx_data;
   logic [8:0] ctl_q[$];
   int failures, checked, n_trig, n_clr;
   gpb_if gpb_if_inst ();
   gpb_dev gpb_dev_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus(gpb_if_inst.dev),
      .my_addr_i(MY), .rx_data_o(dev_rx_data), .rx_end_o(dev_rx_end),
      .rx_valid_o(dev_rx_valid), .rx_ready_i(dev_rx_ready), .tx_data_i(tx_data),
      .tx_end_i(tx_end), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rsv_i(rsv),
      .status_i(status), .ist_i(ist), .listen_o(listen), .talk_o(talk), .remote_o(remote),
      .lockout_o(lockout), .trigger_o(trig), .clear_o(clr));
   gpb_ctl gpb_ctl_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .bus(gpb_if_inst.ctl),
      .cmd_data_i(cmd_data), .cmd_atn_i(cmd_atn), .cmd_end_i(cmd_end),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .ifc_i(ifc), .ren_i(ren),
      .poll_i(poll), .poll_data_o(poll_data), .poll_valid_o(poll_valid),
      .listen_i(ctl_listen), .rx_data_o(ctl_rx_data), .rx_end_o(ctl_rx_end),
      .rx_valid_o(ctl_rx_valid), .srq_o(srq));
   gpb_link_props gpb_link_props_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .dio(gpb_if_inst.dio), .dev_dio_oe(gpb_if_inst.dev_dio_oe), .dav(gpb_if_inst.dav),
      .nrfd(gpb_if_inst.nrfd), .ndac(gpb_if_inst.ndac), .atn(gpb_if_inst.atn),
      .eoi(gpb_if_inst.eoi), .ifc(gpb_if_inst.ifc), .dev_dav_o(gpb_if_inst.dev_dav_o),
      .dev_dav_oe(gpb_if_inst.dev_dav_oe));
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   // pulses are one cycle wide, so they are caught on every edge
   always @(posedge clk_sys_i) begin
      if (ctl_rx_valid === 1'b1) ctl_q.push_back({ctl_rx_end, ctl_rx_data});
      if (trig === 1'b1) n_trig++;
      if (clr === 1'b1) n_clr++;
   end
   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report;
      if (failures == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic give_up(input string what);
      failures++;
      $display("CHECK FAILED %s expected progress seen timeout", what);
      final_report();
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   // attention only turns while the source is idle; the flip takes no byte
   task automatic set_atn(input logic a);
      int i;
      cmd_atn = a;
      for (i = 0; i < 50 && gpb_if_inst.atn !== a; i++) begin
         cmd_valid = 1'b1;
         tick(1);
      end
      if (i == 0) return;
      cmd_valid = 1'b0;
      tick(1);
      if (i == 50) give_up("attention");
   endtask
   task automatic put(input logic [7:0] d, input logic a, input logic e);
      int i;
      set_atn(a);
      cmd_data = d;
      cmd_end = e;
      cmd_valid = 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys_i);
         if (cmd_ready === 1'b1) break;
      end
      #1;
      cmd_valid = 1'b0;
      if (i == 50) give_up("command take");
   endtask
   task automatic idle;
      int i;
      for (i = 0; i < 60 && cmd_ready !== 1'b1; i++) tick(1);
      if (i == 60) give_up("source idle");
   endtask
   task automatic cmd(input logic [7:0] d);
      put(d, 1'b1, 1'b0);
      idle();
   endtask
   task automatic talk_byte(input logic [7:0] d, input logic e);
      int i;
      tx_data = d;
      tx_end = e;
      tx_valid = 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys_i);
         if (tx_ready === 1'b1) break;
      end
      #1;
      tx_valid = 1'b0;
      tick(1);
      if (i == 50) give_up("talk take");
   endtask
   task automatic pop(input logic [8:0] exp);
      int i;
      for (i = 0; i < 60 && dev_rx_valid !== 1'b1; i++) tick(1);
      if (i == 60) give_up("device rx");
      chk("device rx", exp, {dev_rx_end, dev_rx_data});
      dev_rx_ready = 1'b1;
      tick(1);
      dev_rx_ready = 1'b0;
      tick(1);
   endtask
   task automatic ctl_got(input logic [8:0] exp);
      int i;
      for (i = 0; i < 200 && ctl_q.size() == 0; i++) tick(1);
      if (i == 200) give_up("controller rx");
      chk("controller rx", exp, ctl_q[0]);
      ctl_q.delete(0);
   endtask
   task automatic ppoll(input logic [7:0] exp);
      int i;
      poll = 1'b1;
      tick(1);
      poll = 1'b0;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_sys_i);
         if (poll_valid === 1'b1) break;
      end
      if (i == 50) give_up("poll");
      chk("poll answer", {1'b0, exp}, {1'b0, poll_data});
      tick(1);
   endtask
   initial begin
      {cmd_atn, cmd_end, cmd_valid, ifc, ren, poll, ctl_listen} = '0;
      {dev_rx_ready, tx_end, tx_valid, rsv, ist} = '0;
      {cmd_data, tx_data, status} = '0;
      rst_b_i = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      rst_b_i = 1'b1;
      ren = 1'b1;
      tick(2);
      cmd({3'h1, OTHER});
      chk("listen other", 9'h000, {8'h00, listen});
      cmd({3'h5, MY});
      chk("listen", 9'h001, {8'h00, listen});
      chk("remote", 9'h001, {8'h00, remote});
      // two words fill the buffer, the third must wait on the wire
      put(8'h11, 1'b0, 1'b0);
      idle();
      put(8'h22, 1'b0, 1'b0);
      idle();
      put(8'h33, 1'b0, 1'b1);
      tick(20);
      chk("source stalled", 9'h000, {8'h00, cmd_ready});
      pop(9'h011);
      pop(9'h022);
      pop(9'h133);
      idle();
      foreach (TC_SEQ[i]) cmd(TC_SEQ[i]);
      tick(2);
      chk("triggers", 9'h001, n_trig[8:0]);
      chk("clears", 9'h002, n_clr[8:0]);
      cmd({3'h1, MY});
      cmd(8'h11);
      cmd(8'h01);
      chk("remote lock", 9'h003, {7'h00, remote, lockout});
      ren = 1'b0;
      tick(3);
      chk("remote off", 9'h000, {7'h00, remote, lockout});
      ren = 1'b1;
      cmd({3'h1, MY});
      cmd(8'h01);
      chk("go local", 9'h000, {8'h00, remote});
      cmd(8'h05);
      cmd(8'h6b);
      ist = 1'b1;
      ppoll(8'h08);
      ist = 1'b0;
      ppoll(8'h00);
      cmd(8'h15);
      ist = 1'b1;
      ppoll(8'h00);
      cmd(8'h3f);
      rsv = 1'b1;
      status = 8'h05;
      tick(3);
      chk("service request", 9'h001, {8'h00, srq});
      cmd(8'h18);
      cmd({3'h2, MY});
      chk("talk", 9'h001, {8'h00, talk});
      ctl_listen = 1'b1;
      set_atn(1'b0);
      ctl_got(9'h045);
      set_atn(1'b1);
      tick(4);
      ctl_q.delete();
      cmd(8'h19);
      rsv = 1'b0;
      set_atn(1'b0);
      talk_byte(8'h5a, 1'b0);
      talk_byte(8'ha5, 1'b1);
      ctl_got(9'h05a);
      ctl_got(9'h1a5);
      cmd({3'h2, OTHER});
      chk("talk other", 9'h000, {8'h00, talk});
      cmd({3'h1, MY});
      cmd({3'h2, MY});
      chk("addressed", 9'h003, {7'h00, listen, talk});
      ifc = 1'b1;
      tick(3);
      ifc = 1'b0;
      tick(2);
      chk("after clear", 9'h000, {7'h00, listen, talk});
      final_report();
   end
endmodule
